// [common/ppjs_pkg.sv]
package ppjs_pkg;

  // Data widths of the sampled loop and of the AHB-Lite register port
  localparam int DATA_W = 16;
  localparam int JET_W = 15;
  localparam int TAG_W = 2;
  localparam int ADDR_W = 8;
  localparam int HDATA_W = 32;

  // Ones-complement tags: +1, -1, +0 and -0
  localparam logic [TAG_W-1:0] TAG_ZERO = 2'h0;
  localparam logic [TAG_W-1:0] TAG_POS = 2'h1;
  localparam logic [TAG_W-1:0] TAG_NEG = 2'h2;
  localparam logic [TAG_W-1:0] TAG_NZERO = 2'h3;

  // Jet codes, octal 00120, 00240, 00005, 00012 and 00000
  localparam logic [JET_W-1:0] YAW_POS_JETS = 15'h0050;
  localparam logic [JET_W-1:0] YAW_NEG_JETS = 15'h00a0;
  localparam logic [JET_W-1:0] RP_POS_JETS = 15'h0005;
  localparam logic [JET_W-1:0] RP_NEG_JETS = 15'h000a;
  localparam logic [JET_W-1:0] JETS_OFF = 15'h0000;

  // Autopilot mode codes in ones complement: +0 and -1
  localparam logic [1:0] MODE_PLUS_ZERO = 2'h0;
  localparam logic [1:0] MODE_MINUS_ONE = 2'h2;

  // Loop modes, one-hot
  typedef enum logic [1:0] {
    PPJS_EXO = 2'b01,
    PPJS_DAMP = 2'b10
  } ppjs_mode_t;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ERR_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RATE_LIMIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BIAS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DAMP_LIMIT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TRIM_TAN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DRAG_BIT = 1;
  localparam int ST_JET_LSB = 0;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_YTAG_LSB = 20;
  localparam int ST_PTAG_LSB = 22;
  localparam int ST_EN_BIT = 24;

  // Reset values; rates and angles carry 128 LSB per degree
  localparam logic [DATA_W-1:0] ERR_LIMIT_RST = 16'h0100;
  localparam logic [DATA_W-1:0] RATE_LIMIT_RST = 16'h0100;
  localparam logic [DATA_W-1:0] BIAS_RST = 16'h0040;
  localparam logic [DATA_W-1:0] DAMP_LIMIT_RST = 16'h0100;
  localparam logic [DATA_W-1:0] TRIM_TAN_RST = 16'h0000;
  localparam int TAN_FRAC = 8;

  // Sample timing
  localparam real SAMPLE_PERIOD_S = 0.1;
  localparam real CLK_FREQ_HZ = 100.0e6;
  localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_S * CLK_FREQ_HZ);

  // AHB-Lite encodings
  localparam logic HRESP_OKAY = 1'b0;

endpackage : ppjs_pkg

// [rtl/ppjs_axis.sv]
`timescale 1ns/10ps
module ppjs_axis
  import ppjs_pkg::*;
#(
  parameter int W = ppjs_pkg::DATA_W
) (
  input wire logic core_clk_i,                       // Clock, only for checks
  input wire logic srst_i,                           // Sync reset, active high
  input wire logic signed [W-1:0] err_i,             // Attitude error
  input wire logic signed [W-1:0] rate_i,            // Body rate
  input wire logic [W-1:0] err_lim_i,                // Error limit
  input wire logic [W-1:0] rate_lim_i,               // Rate limit
  input wire logic [W-1:0] bias_i,                   // Dead-zone bias
  input wire logic damp_i,                           // Rate damper mode
  input wire logic [W-1:0] damp_lim_i,               // Damper rate limit
  output logic [ppjs_pkg::TAG_W-1:0] tag_o           // Merged tag
);
  import ppjs_pkg::*;

  localparam int XW = W + 2;

  // Signed test of a value against a symmetric limit
  function automatic logic [TAG_W-1:0] limit_tag(input logic signed [XW-1:0] v,
                                                 input logic signed [XW-1:0] lim);
    if (v > lim) begin
      limit_tag = TAG_POS;
    end else if (v < -lim) begin
      limit_tag = TAG_NEG;
    end else begin
      limit_tag = TAG_ZERO;
    end
  endfunction : limit_tag

  logic signed [XW-1:0] err_x, rate_x, elim_x, rlim_x, rlim2_x, dlim_x, bias_x, biased_x;
  logic [TAG_W-1:0] e_tag, v_tag, hi_tag;

  // Widened operands so the bias and the doubled limit never wrap
  assign err_x = XW'(err_i);
  assign rate_x = XW'(rate_i);
  assign elim_x = XW'($signed({1'b0, err_lim_i}));
  assign rlim_x = XW'($signed({1'b0, rate_lim_i}));
  assign rlim2_x = XW'(rlim_x <<< 1);
  assign dlim_x = XW'($signed({1'b0, damp_lim_i}));
  assign bias_x = XW'($signed({1'b0, bias_i}));
  // Bias follows the rate sign; a zero rate leaves the error unbiased
  assign biased_x = (rate_x > 0) ? XW'(err_x - bias_x) :
                    (rate_x < 0) ? XW'(err_x + bias_x) : err_x;
  assign e_tag = limit_tag(biased_x, elim_x);
  assign v_tag = limit_tag(rate_x, rlim_x);
  assign hi_tag = limit_tag(rate_x, rlim2_x);

  // Error tag is negated so a positive merged tag always asks for negative jets
  always_comb begin
    if (damp_i) begin
      tag_o = limit_tag(rate_x, dlim_x);
    end else if (hi_tag != TAG_ZERO) begin
      tag_o = hi_tag;
    end else if (e_tag == TAG_ZERO) begin
      tag_o = v_tag;
    end else begin
      tag_o = ~e_tag | v_tag;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_box;
    !damp_i && (e_tag == TAG_ZERO) && (v_tag == TAG_ZERO) |-> tag_o == TAG_ZERO;
  endproperty
  a_box: assert property (p_box) else $error("jets not off inside the dead zone");

  property p_upper;
    !damp_i && (rate_x > rlim2_x) |-> tag_o == TAG_POS;
  endproperty
  a_upper: assert property (p_upper) else $error("upper rate bound not opposed");

  property p_stop;
    !damp_i && (biased_x > elim_x) && (rate_x > rlim_x) && (rate_x <= rlim2_x)
      |-> tag_o == TAG_NZERO;
  endproperty
  a_stop: assert property (p_stop) else $error("positive jets not stopped");

  property p_bias;
    !damp_i && (rate_x > 0) && (rate_x <= rlim_x) && (err_x - bias_x > elim_x)
      |-> tag_o == TAG_NEG;
  endproperty
  a_bias: assert property (p_bias) else $error("biased error not used");

  property p_damp;
    damp_i && (rate_x <= dlim_x) && (rate_x >= -dlim_x) |-> tag_o == TAG_ZERO;
  endproperty
  a_damp: assert property (p_damp) else $error("damper fired below limit");

endmodule : ppjs_axis

// [rtl/ppjs_top.sv]
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module ppjs_top
  import ppjs_pkg::*;
#(
  parameter int W = ppjs_pkg::DATA_W,
  parameter int SAMPLE_CYCLES = ppjs_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk_i,                           // 100 MHz clock
  input wire logic srst_i,                               // Sync reset, active high
  input wire logic hsel_i,                               // AHB slave select
  input wire logic [ppjs_pkg::HDATA_W-1:0] haddr_i,      // AHB address
  input wire logic [1:0] htrans_i,                       // AHB transfer type
  input wire logic hwrite_i,                             // AHB write
  input wire logic [2:0] hsize_i,                        // AHB size, word only
  input wire logic hready_i,                             // AHB bus ready
  input wire logic [ppjs_pkg::HDATA_W-1:0] hwdata_i,     // AHB write data
  output logic [ppjs_pkg::HDATA_W-1:0] hrdata_o,         // AHB read data
  output logic hreadyout_o,                              // AHB slave ready
  output logic hresp_o,                                  // AHB response
  input wire logic signed [W-1:0] yaw_err_i,             // Yaw attitude error
  input wire logic signed [W-1:0] yaw_rate_i,            // Yaw body rate
  input wire logic signed [W-1:0] pitch_err_i,           // Pitch attitude error
  input wire logic signed [W-1:0] pitch_rate_i,          // Pitch body rate
  input wire logic signed [W-1:0] roll_rate_i,           // Roll body rate
  output logic [ppjs_pkg::JET_W-1:0] jet_word_o,         // Jet driver word
  output logic [1:0] autopilot_mode_code_o,              // Mode code
  output logic sample_strobe_o                           // Sample pulse
);
  import ppjs_pkg::*;

  localparam int CW = (SAMPLE_CYCLES > 2) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam logic [JET_W-1:0] YAW_MASK = YAW_POS_JETS | YAW_NEG_JETS;
  localparam logic [JET_W-1:0] RP_MASK = RP_POS_JETS | RP_NEG_JETS;

  typedef struct packed {
    logic [CW-1:0] div_cnt;
    logic strobe;
    logic ctrl_en;
    logic drag_threshold_switch;
    logic [W-1:0] err_limit;
    logic [W-1:0] rate_limit;
    logic [W-1:0] bias;
    logic [W-1:0] damp_limit;
    logic [W-1:0] trim_tan;
    ppjs_mode_t mode;
    logic [1:0] mode_code;
    logic [JET_W-1:0] jet;
    logic [TAG_W-1:0] yaw_tag;
    logic [TAG_W-1:0] pitch_tag;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [HDATA_W-1:0] hrdata;
    logic hready;
  } ppjs_state_t;

  ppjs_state_t st_r;
  ppjs_state_t st_nxt;

  // Tag to jet code; both ones-complement zeros select the off code
  function automatic logic [JET_W-1:0] jet_code(input logic [TAG_W-1:0] tag,
                                                input logic [JET_W-1:0] pos_code,
                                                input logic [JET_W-1:0] neg_code);
    if (tag == TAG_POS) begin
      jet_code = neg_code;
    end else if (tag == TAG_NEG) begin
      jet_code = pos_code;
    end else begin
      jet_code = JETS_OFF;
    end
  endfunction : jet_code

  logic damp_now;
  logic signed [2*W-1:0] coord_prod;
  logic signed [W-1:0] coord_rate;
  logic signed [W-1:0] yaw_rate_eff;
  logic [TAG_W-1:0] yaw_tag_c;
  logic [TAG_W-1:0] pitch_tag_c;
  logic ahb_take;

  // Mode used by this sample follows the switch as it stands at the strobe
  assign damp_now = st_r.drag_threshold_switch;

  // Yaw damper band is centred on roll rate times tan(trim); overflow wraps
  assign coord_prod = roll_rate_i * $signed(st_r.trim_tan);
  assign coord_rate = coord_prod[TAN_FRAC +: W];
  assign yaw_rate_eff = damp_now ? W'(yaw_rate_i - coord_rate) : yaw_rate_i;

  // Same axis logic for yaw and pitch
  ppjs_axis #(.W(W)) u_yaw (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .err_i(yaw_err_i),
    .rate_i(yaw_rate_eff),
    .err_lim_i(st_r.err_limit),
    .rate_lim_i(st_r.rate_limit),
    .bias_i(st_r.bias),
    .damp_i(damp_now),
    .damp_lim_i(st_r.damp_limit),
    .tag_o(yaw_tag_c)
  );

  ppjs_axis #(.W(W)) u_pitch (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .err_i(pitch_err_i),
    .rate_i(pitch_rate_i),
    .err_lim_i(st_r.err_limit),
    .rate_lim_i(st_r.rate_limit),
    .bias_i(st_r.bias),
    .damp_i(damp_now),
    .damp_lim_i(st_r.damp_limit),
    .tag_o(pitch_tag_c)
  );

  // Address phase accepted: selected, bus ready, NONSEQ or SEQ
  assign ahb_take = hsel_i && hready_i && htrans_i[1];

  // Next state: divider, sample evaluation, register writes, reads
  always_comb begin
    st_nxt = st_r;
    // Sample divider: one-cycle strobe every SAMPLE_CYCLES
    st_nxt.strobe = (st_r.div_cnt == CW'(SAMPLE_CYCLES - 1));
    st_nxt.div_cnt = st_nxt.strobe ? '0 : CW'(st_r.div_cnt + 1'b1);
    // Evaluate and latch the jet word only at the strobe
    if (st_r.strobe) begin
      st_nxt.mode = damp_now ? PPJS_DAMP : PPJS_EXO;
      st_nxt.mode_code = (st_nxt.mode == PPJS_DAMP) ? MODE_MINUS_ONE
                                                     : MODE_PLUS_ZERO;
      st_nxt.yaw_tag = yaw_tag_c;
      st_nxt.pitch_tag = pitch_tag_c;
      if (st_r.ctrl_en) begin
        // Exact codes replace the word, so jets outside the code go off
        st_nxt.jet = jet_code(yaw_tag_c, YAW_POS_JETS, YAW_NEG_JETS) |
                     jet_code(pitch_tag_c, RP_POS_JETS, RP_NEG_JETS);
      end else begin
        st_nxt.jet = JETS_OFF;
      end
    end
    // Data phase of a write; status is read-only
    st_nxt.wr_pend = ahb_take && hwrite_i;
    st_nxt.wr_addr = haddr_i[ADDR_W-1:0];
    if (st_r.wr_pend) begin
      if (st_r.wr_addr == OFS_CTRL) begin
        st_nxt.ctrl_en = hwdata_i[CTRL_EN_BIT];
        st_nxt.drag_threshold_switch = hwdata_i[CTRL_DRAG_BIT];
      end else if (st_r.wr_addr == OFS_ERR_LIMIT) begin
        st_nxt.err_limit = hwdata_i[W-1:0];
      end else if (st_r.wr_addr == OFS_RATE_LIMIT) begin
        st_nxt.rate_limit = hwdata_i[W-1:0];
      end else if (st_r.wr_addr == OFS_BIAS) begin
        st_nxt.bias = hwdata_i[W-1:0];
      end else if (st_r.wr_addr == OFS_DAMP_LIMIT) begin
        st_nxt.damp_limit = hwdata_i[W-1:0];
      end else if (st_r.wr_addr == OFS_TRIM_TAN) begin
        st_nxt.trim_tan = hwdata_i[W-1:0];
      end
    end
    // Reads see a write finishing in the same cycle; unmapped reads give zero
    if (ahb_take && !hwrite_i) begin
      st_nxt.hrdata = '0;
      if (haddr_i[ADDR_W-1:0] == OFS_CTRL) begin
        st_nxt.hrdata[CTRL_EN_BIT] = st_nxt.ctrl_en;
        st_nxt.hrdata[CTRL_DRAG_BIT] = st_nxt.drag_threshold_switch;
      end else if (haddr_i[ADDR_W-1:0] == OFS_ERR_LIMIT) begin
        st_nxt.hrdata[W-1:0] = st_nxt.err_limit;
      end else if (haddr_i[ADDR_W-1:0] == OFS_RATE_LIMIT) begin
        st_nxt.hrdata[W-1:0] = st_nxt.rate_limit;
      end else if (haddr_i[ADDR_W-1:0] == OFS_BIAS) begin
        st_nxt.hrdata[W-1:0] = st_nxt.bias;
      end else if (haddr_i[ADDR_W-1:0] == OFS_DAMP_LIMIT) begin
        st_nxt.hrdata[W-1:0] = st_nxt.damp_limit;
      end else if (haddr_i[ADDR_W-1:0] == OFS_TRIM_TAN) begin
        st_nxt.hrdata[W-1:0] = st_nxt.trim_tan;
      end else if (haddr_i[ADDR_W-1:0] == OFS_STATUS) begin
        st_nxt.hrdata[ST_JET_LSB +: JET_W] = st_nxt.jet;
        st_nxt.hrdata[ST_MODE_LSB +: 2] = st_nxt.mode_code;
        st_nxt.hrdata[ST_YTAG_LSB +: TAG_W] = st_nxt.yaw_tag;
        st_nxt.hrdata[ST_PTAG_LSB +: TAG_W] = st_nxt.pitch_tag;
        st_nxt.hrdata[ST_EN_BIT] = st_nxt.ctrl_en;
      end
    end
    // Zero wait states, so the slave is always ready
    st_nxt.hready = 1'b1;
    // Synchronous reset values
    if (srst_i) begin
      st_nxt = '0;
      st_nxt.err_limit = W'(ERR_LIMIT_RST);
      st_nxt.rate_limit = W'(RATE_LIMIT_RST);
      st_nxt.bias = W'(BIAS_RST);
      st_nxt.damp_limit = W'(DAMP_LIMIT_RST);
      st_nxt.trim_tan = W'(TRIM_TAN_RST);
      st_nxt.mode = PPJS_EXO;
      st_nxt.mode_code = MODE_PLUS_ZERO;
      st_nxt.jet = JETS_OFF;
      st_nxt.hready = 1'b1;
    end
  end

  // The whole state in one register
  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  // Outputs straight from the state register, except hresp_o, which is tied to OKAY
  assign hrdata_o = st_r.hrdata;
  assign hreadyout_o = st_r.hready;
  assign hresp_o = HRESP_OKAY;
  assign jet_word_o = st_r.jet;
  assign autopilot_mode_code_o = st_r.mode_code;
  assign sample_strobe_o = st_r.strobe;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_strobe_gap;
    sample_strobe_o |=> !sample_strobe_o [*2];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("sample strobe too frequent");

  property p_hold;
    !sample_strobe_o |=> $stable(jet_word_o);
  endproperty
  a_hold: assert property (p_hold) else $error("jet word changed between samples");

  property p_quench;
    sample_strobe_o && ((yaw_tag_c == TAG_ZERO) || (yaw_tag_c == TAG_NZERO))
      |=> (jet_word_o & YAW_MASK) == JETS_OFF;
  endproperty
  a_quench: assert property (p_quench) else $error("yaw jets not quenched");

  property p_yaw_code;
    sample_strobe_o && st_r.ctrl_en && (yaw_tag_c == TAG_POS)
      |=> (jet_word_o & YAW_MASK) == YAW_NEG_JETS;
  endproperty
  a_yaw_code: assert property (p_yaw_code) else $error("wrong yaw jet code");

  property p_rp_code;
    sample_strobe_o && st_r.ctrl_en && (pitch_tag_c == TAG_NEG)
      |=> (jet_word_o & RP_MASK) == RP_POS_JETS;
  endproperty
  a_rp_code: assert property (p_rp_code) else $error("wrong roll/pitch jet code");

  property p_only_coded;
    (jet_word_o & ~(YAW_MASK | RP_MASK)) == JETS_OFF;
  endproperty
  a_only_coded: assert property (p_only_coded) else $error("uncoded jet bit set");

  property p_mode_enter;
    sample_strobe_o && st_r.drag_threshold_switch
      |=> autopilot_mode_code_o == MODE_MINUS_ONE;
  endproperty
  a_mode_enter: assert property (p_mode_enter) else $error("damper mode not entered");

  property p_mode_leave;
    sample_strobe_o && !st_r.drag_threshold_switch
      |=> autopilot_mode_code_o == MODE_PLUS_ZERO;
  endproperty
  a_mode_leave: assert property (p_mode_leave) else $error("mode plus zero not restored");

  property p_read_ready;
    ahb_take && !hwrite_i |=> hreadyout_o && (hresp_o == HRESP_OKAY);
  endproperty
  a_read_ready: assert property (p_read_ready) else $error("read not answered at once");

  c_yaw_fire: cover property (sample_strobe_o && st_r.ctrl_en && yaw_tag_c == TAG_NEG);
  c_stop: cover property (sample_strobe_o && yaw_tag_c == TAG_NZERO);
  c_damp: cover property (sample_strobe_o && st_r.drag_threshold_switch);
  c_write: cover property (st_r.wr_pend && st_r.wr_addr == OFS_CTRL);

endmodule : ppjs_top

// [tb/ppjs_far_model.sv]
`timescale 1ns/10ps
// Sensor side: a fresh measurement lands only between samples
module ppjs_far_model (
  input wire logic clk_i,               // Clock
  input wire logic strobe_i,            // Sample pulse from the block
  input wire logic [4:0][15:0] nxt_i,   // Next measurement set
  output logic [4:0][15:0] meas_o       // Yaw err, yaw rate, pitch err, pitch rate, roll rate
);
  initial meas_o = '0;
  // Never change across the sample edge, so one sample sees one coherent set
  always @(posedge clk_i) begin
    if (strobe_i !== 1'b1) begin
      meas_o <= nxt_i;
    end
  end
endmodule : ppjs_far_model

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  import ppjs_pkg::*;
  localparam int SC = 12;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hready, hresp, strobe;
  logic [14:0] jet, last_jet;
  logic [1:0] mode;
  logic [4:0][15:0] nxt = '0;
  logic [4:0][15:0] meas;
  logic seen = 1'b0;
  logic last_strb = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int gap = 0;

  always #5 clk = ~clk;

  ppjs_top #(.SAMPLE_CYCLES(SC)) i_dut (
    .core_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .yaw_err_i(meas[0]), .yaw_rate_i(meas[1]), .pitch_err_i(meas[2]),
    .pitch_rate_i(meas[3]), .roll_rate_i(meas[4]), .jet_word_o(jet),
    .autopilot_mode_code_o(mode), .sample_strobe_o(strobe));

  ppjs_far_model i_far (.clk_i(clk), .strobe_i(strobe), .nxt_i(nxt), .meas_o(meas));

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_jet(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: jets %h expected %h", $time, got, exp);
    end
  endtask : chk_jet

  task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: mode %b expected %b", $time, got, exp);
    end
  endtask : chk_mode

  // Single AHB-Lite transfer; waits on hready rather than assuming zero wait states
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, exp);
  endtask : rdc

  function automatic logic [4:0][15:0] mk(input logic [15:0] ye, yr, pe, pr, ro);
    return {ro, pr, pe, yr, ye};
  endfunction : mk

  // Load a measurement, let the far side present it, then check the word after the sample
  task automatic run_sample(input logic [4:0][15:0] v, input logic [14:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    nxt <= v;
    repeat (2) @(negedge clk);
    while (strobe !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    chk_jet(jet, exp);
  endtask : run_sample

  // Strobe spacing and jet word hold, watched on the falling edge where outputs are settled
  always @(negedge clk) begin
    if (srst === 1'b0) begin
      gap++;
      if (seen && !last_strb) begin
        chk_jet(jet, last_jet);
      end
      if (strobe === 1'b1) begin
        if (seen) chk_reg(32'(gap), 32'(SC));
        gap = 0;
        seen = 1'b1;
      end
      last_jet = jet;
      last_strb = strobe;
    end
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(OFS_CTRL, 32'h0000_0000);
    rdc(OFS_ERR_LIMIT, 32'(ERR_LIMIT_RST));
    rdc(OFS_RATE_LIMIT, 32'(RATE_LIMIT_RST));
    rdc(OFS_BIAS, 32'(BIAS_RST));
    rdc(OFS_DAMP_LIMIT, 32'(DAMP_LIMIT_RST));
    rdc(OFS_TRIM_TAN, 32'(TRIM_TAN_RST));
    rdc(8'h1c, 32'h0000_0000);
    ahb(1'b1, OFS_STATUS, 32'hffff_ffff);
    rdc(OFS_STATUS, 32'h0000_0000);
    ahb(1'b1, OFS_ERR_LIMIT, 32'habcd_0180);
    rdc(OFS_ERR_LIMIT, 32'h0000_0180);
    ahb(1'b1, OFS_ERR_LIMIT, 32'(ERR_LIMIT_RST));
    rdc(OFS_ERR_LIMIT, 32'(ERR_LIMIT_RST));
    chk_mode(mode, MODE_PLUS_ZERO);
    $display("Test registers done");
    // Exo attitude loop: each row pairs a yaw case with a pitch case
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    run_sample(mk(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000), 15'h0000);
    run_sample(mk(16'h0000, 16'h0180, 16'h0000, 16'hfe80, 16'h0000), 15'h00a5);
    run_sample(mk(16'h0200, 16'h0000, 16'hfe00, 16'h0000, 16'h0000), 15'h005a);
    run_sample(mk(16'h0200, 16'h0180, 16'h0200, 16'h0250, 16'h0000), 15'h000a);
    run_sample(mk(16'h0120, 16'h0010, 16'hfee0, 16'hfff0, 16'h0000), 15'h0000);
    run_sample(mk(16'hfe00, 16'hfdb0, 16'h0141, 16'h0001, 16'h0000), 15'h0055);
    run_sample(mk(16'h0000, 16'h0100, 16'h0000, 16'h0101, 16'h0000), 15'h000a);
    $display("Test exo loop done");
    // Damper mode entered, left and re-entered
    ahb(1'b1, OFS_CTRL, 32'h0000_0003);
    run_sample(mk(16'h0200, 16'h0000, 16'h0200, 16'h0180, 16'h0000), 15'h000a);
    chk_mode(mode, MODE_MINUS_ONE);
    ahb(1'b1, OFS_TRIM_TAN, 32'h0000_0100);
    run_sample(mk(16'h0000, 16'h0200, 16'h0000, 16'h00f0, 16'h0200), 15'h0000);
    run_sample(mk(16'h0000, 16'h0000, 16'h0000, 16'h00f0, 16'h0200), 15'h0050);
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    run_sample(mk(16'h0200, 16'h0000, 16'h0200, 16'h00f0, 16'h0200), 15'h0055);
    chk_mode(mode, MODE_PLUS_ZERO);
    ahb(1'b1, OFS_CTRL, 32'h0000_0003);
    run_sample(mk(16'h0200, 16'h0000, 16'h0200, 16'h00f0, 16'h0200), 15'h0050);
    chk_mode(mode, MODE_MINUS_ONE);
    // Disabled: tags still formed, jets held off
    ahb(1'b1, OFS_CTRL, 32'h0000_0002);
    run_sample(mk(16'h0200, 16'h0000, 16'h0200, 16'h00f0, 16'h0200), 15'h0000);
    rdc(OFS_STATUS, 32'h0022_0000);
    chk_reg(32'(hresp), 32'(HRESP_OKAY));
    $display("Test damper done");
    give_verdict();
  end
endmodule : tb
